// File: smeq_top.sv
// Status line arbiter that picks the shown message and feeds the error queue.
`timescale 1ns/10ps
module smeq_top
(
   input  wire logic                            clk_i,       // System clock, 40 MHz.
   input  wire logic                            sys_rst_i,   // Async reset, high.
   input  wire logic                            msg_vld_i,   // New message strobe.
   input  smeq_pkg::smeq_msg_t                  msg_i,       // New message.
   input  wire logic                            restart_i,   // Restart key pulse.
   input  wire logic                            valid_key_i, // Any valid key pulse.
   input  wire logic                            cond_chg_i,  // Status condition changed.
   input  wire logic                            fail_fix_i,  // Failure condition corrected.
   input  wire logic                            rtl_i,       // Remote-to-local pulse.
   input  wire logic                            query_i,     // Error queue query strobe.
   output smeq_pkg::smeq_msg_t                  shown_o,     // Displayed message.
   output smeq_pkg::smeq_resp_t                 resp_o,      // Query answer.
   output logic [smeq_pkg::SMEQ_CNT_W-1:0]      err_cnt_o    // Pending error count.
);
   import smeq_pkg::*;

   smeq_msg_t                  shown_q;
   logic [SMEQ_TMR_W-1:0]      tmr_q;
   logic                       accept;
   logic                       enq;
   logic                       momentary;
   logic                       expire;
   logic                       clr;
   logic [SMEQ_CNT_W-1:0]      cnt_w;

   function automatic logic is_status(input smeq_class_t c);
      return (c == SMEQ_S_STATUS) || (c == SMEQ_M_STATUS);
   endfunction : is_status

   function automatic logic is_moment(input smeq_class_t c);
      return (c == SMEQ_M_STATUS) || (c == SMEQ_M_WARN);
   endfunction : is_moment

   // Classes compare by their code, which rises with priority.
   always_comb
   begin
      accept = 1'b0;
      if (msg_vld_i && msg_i.cls != SMEQ_NONE)
      begin
         if (msg_i.cls > shown_q.cls)
            accept = 1'b1;
         else if (msg_i.cls == shown_q.cls)
            accept = (is_status(msg_i.cls) && is_status(shown_q.cls))
                     || (is_moment(msg_i.cls) && is_moment(shown_q.cls));
      end
   end

   // Lower or refused warnings, errors and failures still log their number.
   assign enq = msg_vld_i && (msg_i.cls >= SMEQ_M_WARN);

   assign momentary = is_moment(shown_q.cls);
   assign expire    = momentary && (tmr_q == SMEQ_TMR_W'(SMEQ_HOLD_CYC - 1));

   always_comb
   begin
      clr = 1'b0;
      unique case (shown_q.cls)
         SMEQ_NONE     : clr = 1'b0;
         SMEQ_S_STATUS : clr = cond_chg_i || restart_i;
         SMEQ_M_STATUS : clr = expire;
         SMEQ_M_WARN   : clr = expire;
         SMEQ_S_ERROR  : clr = valid_key_i || (rtl_i && shown_q.from_bus);
         SMEQ_S_FAIL   : clr = restart_i || fail_fix_i;
         default       : clr = 1'b1;
      endcase
   end

   // A new acceptable message wins over a clear in the same cycle.
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         shown_q <= '0;
      else if (accept)
         shown_q <= msg_i;
      else if (clr)
         shown_q <= '0;
   end

   // The counter is long, so it only runs while a momentary message is shown.
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         tmr_q <= '0;
      else if (accept || !momentary || expire)
         tmr_q <= '0;
      else
         tmr_q <= tmr_q + 27'h0000001;
   end

   smeq_errq u_errq
   (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .push_i    (enq),
      .err_i     (msg_i.err),
      .pop_i     (query_i),
      .resp_o    (resp_o),
      .count_o   (cnt_w)
   );

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         err_cnt_o <= '0;
      else
         err_cnt_o <= cnt_w;
   end

   assign shown_o = shown_q;

   property p_higher;
      @(posedge clk_i) disable iff (sys_rst_i)
      (msg_vld_i && msg_i.cls > shown_q.cls) |=> (shown_q == $past(msg_i));
   endproperty
   a_higher: assert property (p_higher) else $error("Higher class not shown.");

   property p_same_err;
      @(posedge clk_i) disable iff (sys_rst_i)
      (msg_vld_i && msg_i.cls == SMEQ_S_ERROR && shown_q.cls == SMEQ_S_ERROR && !valid_key_i
       && !(rtl_i && shown_q.from_bus)) |=> $stable(shown_q);
   endproperty
   a_same_err: assert property (p_same_err) else $error("Equal error overwrote.");

   property p_lower;
      @(posedge clk_i) disable iff (sys_rst_i)
      (msg_vld_i && msg_i.cls < shown_q.cls && msg_i.cls != SMEQ_NONE)
      |=> (shown_q == $past(shown_q) || shown_q.cls == SMEQ_NONE);
   endproperty
   a_lower: assert property (p_lower) else $error("Lower class shown.");

   property p_status_noq;
      @(posedge clk_i) disable iff (sys_rst_i)
      (msg_vld_i && is_status(msg_i.cls) && !query_i) |=> (cnt_w == $past(cnt_w));
   endproperty
   a_status_noq: assert property (p_status_noq) else $error("Status class enqueued.");

   property p_fail_hold;
      @(posedge clk_i) disable iff (sys_rst_i)
      (shown_q.cls == SMEQ_S_FAIL && !restart_i && !fail_fix_i && !accept)
      |=> (shown_q.cls == SMEQ_S_FAIL);
   endproperty
   a_fail_hold: assert property (p_fail_hold) else $error("Failure cleared early.");

   property p_expire;
      @(posedge clk_i) disable iff (sys_rst_i)
      (expire && !accept) |=> (shown_q.cls == SMEQ_NONE);
   endproperty
   a_expire: assert property (p_expire) else $error("Momentary not cleared.");

   property p_timer_restart;
      @(posedge clk_i) disable iff (sys_rst_i)
      accept |=> (tmr_q == 27'h0000000);
   endproperty
   a_timer_restart: assert property (p_timer_restart) else $error("Timer not restarted.");

   property p_key_clr;
      @(posedge clk_i) disable iff (sys_rst_i)
      (shown_q.cls == SMEQ_S_ERROR && valid_key_i && !accept) |=> (shown_q.cls == SMEQ_NONE);
   endproperty
   a_key_clr: assert property (p_key_clr) else $error("Key did not clear error.");

endmodule : smeq_top

// File: smeq_pkg.sv
// Package with classes, timing constants and carrier types for the status message and error queue.
package smeq_pkg;

   typedef enum logic [2:0]
   {
      SMEQ_NONE     = 3'b000,
      SMEQ_S_STATUS = 3'b001,
      SMEQ_M_STATUS = 3'b010,
      SMEQ_M_WARN   = 3'b011,
      SMEQ_S_ERROR  = 3'b100,
      SMEQ_S_FAIL   = 3'b101
   } smeq_class_t;

   localparam int          SMEQ_ERR_W      = 16;
   localparam int          SMEQ_MSG_W      = 8;
   localparam int          SMEQ_DEPTH      = 16;
   localparam int          SMEQ_PTR_W      = 4;
   localparam int          SMEQ_CNT_W      = 5;
   localparam logic [15:0] SMEQ_OVF_CODE   = 16'hFEA2;
   localparam logic [15:0] SMEQ_EMPTY_CODE = 16'h0000;
   localparam int          SMEQ_CLK_HZ     = 40000000;
   localparam int          SMEQ_HOLD_S     = 3;
   localparam int          SMEQ_HOLD_CYC   = SMEQ_HOLD_S * SMEQ_CLK_HZ;
   localparam int          SMEQ_TMR_W      = 27;

   typedef struct packed
   {
      smeq_class_t             cls;
      logic [SMEQ_MSG_W-1:0]   id;
      logic                    from_bus;
      logic [SMEQ_ERR_W-1:0]   err;
   } smeq_msg_t;

   typedef struct packed
   {
      logic                    valid;
      logic [SMEQ_ERR_W-1:0]   err;
   } smeq_resp_t;

endpackage : smeq_pkg

// File: smeq_errq.sv
// Sixteen-entry error-number queue with overflow marking and empty answer.
`timescale 1ns/10ps
module smeq_errq
(
   input  wire logic                           clk_i,   // System clock.
   input  wire logic                           sys_rst_i, // Async reset, high.
   input  wire logic                           push_i,  // Enqueue one number.
   input  wire logic [smeq_pkg::SMEQ_ERR_W-1:0] err_i,  // Number to enqueue.
   input  wire logic                           pop_i,   // Query strobe.
   output smeq_pkg::smeq_resp_t                resp_o,  // Query answer.
   output logic [smeq_pkg::SMEQ_CNT_W-1:0]     count_o  // Entries held.
);
   import smeq_pkg::*;

   logic [SMEQ_ERR_W-1:0] mem_q [SMEQ_DEPTH];
   logic [SMEQ_PTR_W-1:0] rd_q;
   logic [SMEQ_CNT_W-1:0] cnt_q;
   logic                  empty;
   logic                  full;
   logic                  do_pop;
   logic [SMEQ_PTR_W-1:0] last_idx;
   logic [SMEQ_PTR_W-1:0] wr_idx;

   assign empty    = (cnt_q == '0);
   assign full     = (cnt_q == SMEQ_CNT_W'(SMEQ_DEPTH));
   assign do_pop   = pop_i && !empty;
   // With a pop in the same cycle the write slot still uses the count from before the pop.
   assign wr_idx   = rd_q + cnt_q[SMEQ_PTR_W-1:0];
   assign last_idx = rd_q + SMEQ_PTR_W'(SMEQ_DEPTH - 1);

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         rd_q <= '0;
      else if (do_pop)
         rd_q <= rd_q + 4'h1;
   end

   // A push on a full queue that is also popped this cycle fits, so no overflow then.
   always_ff @(posedge clk_i)
   begin
      if (push_i && full && !do_pop)
         mem_q[last_idx] <= SMEQ_OVF_CODE;
      else if (push_i)
         mem_q[wr_idx] <= err_i;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         cnt_q <= '0;
      else if (push_i && !do_pop && !full)
         cnt_q <= cnt_q + 5'h01;
      else if (do_pop && !push_i)
         cnt_q <= cnt_q - 5'h01;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         resp_o <= '0;
      else
      begin
         resp_o.valid <= pop_i;
         resp_o.err   <= empty ? SMEQ_EMPTY_CODE : mem_q[rd_q];
      end
   end

   assign count_o = cnt_q;

   property p_empty_zero;
      @(posedge clk_i) disable iff (sys_rst_i)
      (pop_i && empty) |=> (resp_o.valid && resp_o.err == 16'h0000);
   endproperty
   a_empty_zero: assert property (p_empty_zero) else $error("Empty query not zero.");

   property p_cap;
      @(posedge clk_i) disable iff (sys_rst_i)
      cnt_q <= 5'h10;
   endproperty
   a_cap: assert property (p_cap) else $error("Queue count above sixteen.");

   property p_ovf;
      @(posedge clk_i) disable iff (sys_rst_i)
      (push_i && full && !pop_i) |=> (mem_q[$past(last_idx)] == 16'hFEA2 && full);
   endproperty
   a_ovf: assert property (p_ovf) else $error("Overflow code missing.");

   property p_pop_dec;
      @(posedge clk_i) disable iff (sys_rst_i)
      (pop_i && !empty && !push_i) |=> (cnt_q == $past(cnt_q) - 5'h01);
   endproperty
   a_pop_dec: assert property (p_pop_dec) else $error("Pop did not remove entry.");

endmodule : smeq_errq

// File: smeq_ctrl.sv
// System controller model that drains the error queue one query at a time.
`timescale 1ns/10ps
module smeq_ctrl
(
   input  wire logic            clk_i,   // System clock.
   input  smeq_pkg::smeq_resp_t resp_i,  // Query answer.
   output logic                 query_o  // Query strobe.
);
   import smeq_pkg::*;

   initial query_o = 1'b0;

   // Waiting for each answer before the next query keeps numbers in arrival order.
   task automatic ask(output logic [15:0] err, output logic ok);
      int n;
      @(negedge clk_i);
      query_o = 1'b1;
      @(negedge clk_i);
      query_o = 1'b0;
      n = 0;
      while (resp_i.valid !== 1'b1 && n < 4)
      begin
         @(negedge clk_i);
         n++;
      end
      ok  = (resp_i.valid === 1'b1);
      err = resp_i.err;
   endtask : ask
endmodule : smeq_ctrl

// File: smeq_top_bench.sv
// Self-checking bench for the status message arbiter and error queue.
`timescale 1ns/10ps
module smeq_top_bench;
   import smeq_pkg::*;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        msg_vld = 1'b0;
   smeq_msg_t   msg = '0;
   logic [4:0]  keys = 5'h00; // Restart, valid key, condition, fix, remote-to-local.
   logic        query;
   smeq_msg_t   shown;
   smeq_resp_t  resp;
   logic [4:0]  cnt;
   logic [15:0] e;
   logic        ok;
   int          fail_count = 0;
   int          compares = 0;
   int          cycles = 0;

   smeq_top i_smeq_top
   (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .msg_vld_i   (msg_vld),
      .msg_i       (msg),
      .restart_i   (keys[4]),
      .valid_key_i (keys[3]),
      .cond_chg_i  (keys[2]),
      .fail_fix_i  (keys[1]),
      .rtl_i       (keys[0]),
      .query_i     (query),
      .shown_o     (shown),
      .resp_o      (resp),
      .err_cnt_o   (cnt)
   );

   smeq_ctrl i_smeq_ctrl
   (
      .clk_i   (clk_i),
      .resp_i  (resp),
      .query_o (query)
   );

   initial forever #12.5 clk_i = ~clk_i;

   task automatic wrap_up;
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // The run needs well under a thousand cycles; the ceiling only catches a hang.
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         fail_count++;
         wrap_up;
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic send(input smeq_class_t c, input logic [7:0] id, input logic b,
                       input logic [15:0] err);
      @(negedge clk_i);
      msg_vld = 1'b1;
      msg     = '{cls: c, id: id, from_bus: b, err: err};
      @(negedge clk_i);
      msg_vld = 1'b0;
   endtask : send

   task automatic key(input int k);
      @(negedge clk_i);
      keys = 5'h10 >> k;
      @(negedge clk_i);
      keys = 5'h00;
   endtask : key

   task automatic see(input smeq_class_t c, input logic [7:0] id);
      chk("shown class", 16'(c), 16'(shown.cls));
      if (c != SMEQ_NONE)
         chk("shown id", 16'(id), 16'(shown.id));
   endtask : see

   task automatic q(input logic [15:0] exp);
      i_smeq_ctrl.ask(e, ok);
      chk("answer valid", 16'h0001, 16'(ok));
      chk("answer", exp, e);
   endtask : q

   task automatic settle(input logic [4:0] n);
      repeat (2) @(negedge clk_i);
      chk("pending count", 16'(n), 16'(cnt));
   endtask : settle

   task automatic t_rank;
      send(SMEQ_S_STATUS, 8'h01, 1'b0, 16'h0011); see(SMEQ_S_STATUS, 8'h01);
      send(SMEQ_M_STATUS, 8'h02, 1'b0, 16'h0022); see(SMEQ_M_STATUS, 8'h02);
      send(SMEQ_M_WARN, 8'h03, 1'b0, 16'hFF9C); see(SMEQ_M_WARN, 8'h03);
      send(SMEQ_S_ERROR, 8'h04, 1'b0, 16'hFF88); see(SMEQ_S_ERROR, 8'h04);
      send(SMEQ_S_FAIL, 8'h05, 1'b0, 16'h00C8); see(SMEQ_S_FAIL, 8'h05);
      send(SMEQ_S_ERROR, 8'h06, 1'b0, 16'h0064); see(SMEQ_S_FAIL, 8'h05);
      send(SMEQ_S_STATUS, 8'h07, 1'b0, 16'h0077); see(SMEQ_S_FAIL, 8'h05);
      settle(5'd4);
      q(16'hFF9C);
      q(16'hFF88);
      q(16'h00C8);
      q(16'h0064);
      q(16'h0000);
      q(16'h0000);
      key(0); see(SMEQ_NONE, 8'h00);
   endtask : t_rank

   task automatic t_equal;
      send(SMEQ_S_STATUS, 8'h11, 1'b0, 16'h0000);
      send(SMEQ_S_STATUS, 8'h12, 1'b0, 16'h0000); see(SMEQ_S_STATUS, 8'h12);
      send(SMEQ_M_WARN, 8'h13, 1'b0, 16'h0001);
      send(SMEQ_M_WARN, 8'h14, 1'b0, 16'h0002); see(SMEQ_M_WARN, 8'h14);
      send(SMEQ_S_ERROR, 8'h15, 1'b0, 16'h0003);
      send(SMEQ_S_ERROR, 8'h16, 1'b0, 16'h0004); see(SMEQ_S_ERROR, 8'h15);
      settle(5'd4);
      key(1); see(SMEQ_NONE, 8'h00);
      for (int i = 1; i <= 4; i++)
         q(16'(i));
   endtask : t_equal

   task automatic t_clear;
      // Class, from bus, key index, still shown after that key.
      smeq_class_t c [7] = '{SMEQ_S_STATUS, SMEQ_S_STATUS, SMEQ_S_ERROR, SMEQ_S_ERROR,
                             SMEQ_S_FAIL, SMEQ_S_FAIL, SMEQ_S_FAIL};
      logic        b [7] = '{0, 0, 1, 0, 0, 0, 0};
      int          k [7] = '{2, 0, 4, 4, 3, 0, 1};
      logic        s [7] = '{0, 0, 0, 1, 0, 0, 1};
      for (int i = 0; i < 7; i++)
      begin
         send(c[i], 8'(i), b[i], 16'(i));
         key(k[i]);
         see(s[i] ? c[i] : SMEQ_NONE, 8'(i));
         key(1);
         key(0);
      end
      for (int i = 2; i < 7; i++)
         q(16'(i));
   endtask : t_clear

   task automatic t_over;
      for (int i = 0; i < 17; i++)
         send(SMEQ_M_WARN, 8'(i), 1'b0, 16'h0100 + 16'(i));
      settle(5'd16);
      for (int i = 0; i < 15; i++)
         q(16'h0100 + 16'(i));
      q(SMEQ_OVF_CODE);
      q(16'h0000);
   endtask : t_over

   initial
   begin
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
      sys_rst_i = 1'b0;
      t_rank;
      t_equal;
      t_clear;
      t_over;
      // The three-second self-clear needs 120e6 cycles and stays with the design's assertions.
      wrap_up;
   end
endmodule : smeq_top_bench
